//--- logic/ssr_reset_gen.sv
`timescale 1ns/1ps
module ssr_reset_gen #(
  parameter int unsigned TO_SHORT_CYC = ssr_pkg::TO_SHORT_CYC,
  parameter int unsigned TO_LONG_CYC = ssr_pkg::TO_LONG_CYC,
  parameter int unsigned FILT_CYC = ssr_pkg::MR_FILT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supplyLow,
  input wire logic manualResetN,
  input wire logic timeoutSelectIn,
  output ssr_pkg::ssr_rst_out_t rstOut,
  output ssr_pkg::ssr_status_t status
);
  import ssr_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int unsigned MAX_CYC = (TO_LONG_CYC > TO_SHORT_CYC) ? TO_LONG_CYC : TO_SHORT_CYC;
  localparam int unsigned CW = $clog2(MAX_CYC + 1);

  generate
    if (TO_SHORT_CYC < 1 || TO_LONG_CYC < 1) begin : g_bad_timeout
      $error("Timeout periods must be at least one cycle.");
    end
    if (CW > 32) begin : g_bad_width
      $error("Timeout counter wider than 32 bits is not supported.");
    end
  endgenerate

  localparam logic [CW-1:0] LIMIT_SHORT = CW'(TO_SHORT_CYC - 1);
  localparam logic [CW-1:0] LIMIT_LONG = CW'(TO_LONG_CYC - 1);
  localparam logic [RESET_COUNT_W-1:0] COUNT_MAX = '1;

  // ----------------------------------------------------------------------
  // Cause capture
  // ----------------------------------------------------------------------
  logic manualHeld;
  wire causeNow;
  wire causeSupply;
  wire causeManual;

  ssr_mr_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_mr_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinN(manualResetN),
    .heldLow(manualHeld)
  );

  // The supply flag is not filtered: a brown-out must reach the output at once.
  assign causeSupply = supplyLow;
  assign causeManual = manualHeld;
  assign causeNow = causeSupply | causeManual;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  ssr_state_t state_r;
  ssr_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] limit_r;
  logic [CW-1:0] limit_nxt;
  wire timeUp;
  wire enterTiming;
  wire [CW-1:0] limitSel;

  assign timeUp = (cnt_r == limit_r);
  assign enterTiming = (state_r == SSR_ASSERT) && !causeNow;
  assign limitSel = timeoutSelectIn ? LIMIT_LONG : LIMIT_SHORT;
  // The period is fixed when timing starts, so a late change of the select cannot cut it short.
  assign limit_nxt = enterTiming ? limitSel : limit_r;
  // Any new cause clears the count, so every release follows a full period.
  assign cnt_nxt = ((state_r == SSR_TIMING) && !causeNow) ? cnt_r + 1'b1 : '0;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSR_ASSERT: begin
        state_nxt = causeNow ? SSR_ASSERT : SSR_TIMING;
      end
      SSR_TIMING: begin
        if (causeNow) begin
          state_nxt = SSR_ASSERT;
        end else if (timeUp) begin
          state_nxt = SSR_RUN;
        end else begin
          state_nxt = SSR_TIMING;
        end
      end
      SSR_RUN: begin
        state_nxt = causeNow ? SSR_ASSERT : SSR_RUN;
      end
      default: begin
        state_nxt = SSR_ASSERT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= SSR_ASSERT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      limit_r <= LIMIT_LONG;
    end else begin
      limit_r <= limit_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Reset outputs
  // ----------------------------------------------------------------------
  // Both polarities come from one flip-flop pair fed by the same next state,
  // so they can never disagree for a cycle.
  logic rstN_r;
  logic rst_r;
  wire released;

  assign released = (state_nxt == SSR_RUN);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstN_r <= RST_N_RESET;
      rst_r <= ~RST_N_RESET;
    end else begin
      rstN_r <= released;
      rst_r <= ~released;
    end
  end

  assign rstOut.rstN = rstN_r;
  assign rstOut.rst = rst_r;

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  logic timing_r;
  logic causeSupply_r;
  logic causeManual_r;
  logic assertPulse_r;
  logic releasePulse_r;
  logic [RESET_COUNT_W-1:0] resetCount_r;
  wire newAssert;
  wire newRelease;
  wire [RESET_COUNT_W-1:0] resetCount_nxt;
  wire timing_nxt;
  wire causeSupply_nxt;
  wire causeManual_nxt;

  assign newAssert = rstN_r && !released;
  assign newRelease = !rstN_r && released;
  // The count saturates instead of wrapping, so a flapping supply reads as many resets.
  assign resetCount_nxt = (newAssert && resetCount_r != COUNT_MAX) ? resetCount_r + 1'b1
                                                                   : resetCount_r;
  assign timing_nxt = (state_nxt == SSR_TIMING);
  assign causeSupply_nxt = newAssert ? causeSupply : (causeSupply_r | (causeSupply && !released));
  assign causeManual_nxt = newAssert ? causeManual : (causeManual_r | (causeManual && !released));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timing_r <= 1'b0;
    end else begin
      timing_r <= timing_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      causeSupply_r <= 1'b0;
    end else begin
      causeSupply_r <= causeSupply_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      causeManual_r <= 1'b0;
    end else begin
      causeManual_r <= causeManual_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      assertPulse_r <= 1'b0;
    end else begin
      assertPulse_r <= newAssert;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      releasePulse_r <= 1'b0;
    end else begin
      releasePulse_r <= newRelease;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetCount_r <= '0;
    end else begin
      resetCount_r <= resetCount_nxt;
    end
  end

  assign status.timing = timing_r;
  assign status.causeSupply = causeSupply_r;
  assign status.causeManual = causeManual_r;
  assign status.assertPulse = assertPulse_r;
  assign status.releasePulse = releasePulse_r;
  assign status.resetCount = resetCount_r;

endmodule : ssr_reset_gen

//--- shared/ssr_pkg.sv
// How it works
// - Active-low reset output falls as soon as supply is low or manual reset has been low for the filter time.
// - After both causes clear, the low output is held for the full timeout period.
// - The active-high output mirrors the active-low one with the same timing.
// - Manual reset held low keeps reset; the timeout restarts from its rising edge.
package ssr_pkg;

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Timeout periods in milliseconds, the minimum of each selectable range.
  localparam int unsigned TO_SHORT_MS = 10;
  localparam int unsigned TO_LONG_MS = 150;
  // A least time rounds up to whole cycles.
  localparam int unsigned TO_SHORT_CYC = (TO_SHORT_MS * 1000000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam int unsigned TO_LONG_CYC = (TO_LONG_MS * 1000000 + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;

  // Glitch rejection of the manual reset input, in nanoseconds.
  localparam int unsigned MR_GLITCH_NS = 200;
  localparam int unsigned MR_FILT_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least low time that the manual reset source must give, in nanoseconds.
  localparam int unsigned MR_MIN_PULSE_NS = 1000;
  localparam int unsigned MR_MIN_PULSE_CYC = (MR_MIN_PULSE_NS + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------------
  localparam logic RST_N_RESET = 1'h0;
  localparam int unsigned RESET_COUNT_W = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSR_ASSERT = 2'h0,
    SSR_TIMING = 2'h1,
    SSR_RUN = 2'h3
  } ssr_state_t;

  typedef struct packed {
    logic rstN;
    logic rst;
  } ssr_rst_out_t;

  typedef struct packed {
    logic timing;
    logic causeSupply;
    logic causeManual;
    logic assertPulse;
    logic releasePulse;
    logic [RESET_COUNT_W-1:0] resetCount;
  } ssr_status_t;

endpackage : ssr_pkg

//--- logic/ssr_mr_filter.sv
`timescale 1ns/1ps
module ssr_mr_filter #(
  parameter int unsigned FILT_CYC = ssr_pkg::MR_FILT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinN,
  output logic heldLow
);
  import ssr_pkg::*;

  localparam int unsigned CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYC);

  generate
    if (FILT_CYC < 1) begin : g_bad_filt
      $error("Filter length must be at least one cycle.");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Low-time qualifier
  // ----------------------------------------------------------------------
  logic [CW-1:0] lowCnt_r;
  logic [CW-1:0] lowCnt_nxt;
  logic heldLow_r;

  // A release is taken at once, so the timeout starts from the rising edge itself.
  assign lowCnt_nxt = pinN ? '0 : ((lowCnt_r == FILT_MAX) ? lowCnt_r : lowCnt_r + 1'b1);
  assign heldLow = heldLow_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt_r <= '0;
      heldLow_r <= 1'b0;
    end else begin
      lowCnt_r <= lowCnt_nxt;
      heldLow_r <= (lowCnt_nxt == FILT_MAX);
    end
  end

endmodule : ssr_mr_filter

//--- verif/ssr_reset_gen_checker.sv
`timescale 1ns/1ps
module ssr_reset_gen_checker #(
  parameter int unsigned TO_SHORT_CYC = ssr_pkg::TO_SHORT_CYC,
  parameter int unsigned FILT_CYC = ssr_pkg::MR_FILT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supplyLow,
  input wire logic manualResetN,
  input wire logic timeoutSelectIn,
  input wire ssr_pkg::ssr_rst_out_t rstOut,
  input wire ssr_pkg::ssr_status_t status
);
  import ssr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  // The repetition below is fixed at 8, so it only arms for that short count.
  sequence shortStart;
    TO_SHORT_CYC == 8 && $rose(status.timing) && !$past(timeoutSelectIn);
  endsequence
  sequence quietRun;
    (!supplyLow && manualResetN)[*8];
  endsequence
  // Four low samples qualify the request only for filters of four cycles or less.
  sequence manualHeld;
    (FILT_CYC <= 4) ##0 (!manualResetN)[*4];
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  supply_assert_a: assert property (supplyLow |=> !rstOut.rstN)
    else $error("reset output not low after supply low");
  polarity_pair_a: assert property (rstOut.rst == !rstOut.rstN)
    else $error("reset outputs disagree");
  manual_assert_a: assert property (manualHeld |-> ##2 !rstOut.rstN)
    else $error("manual reset not honoured");
  timeout_short_a: assert property (shortStart ##0 quietRun |-> !rstOut.rstN ##1 rstOut.rstN)
    else $error("reset released at wrong time");
  cause_abort_a: assert property (status.timing && supplyLow |=> !status.timing && !rstOut.rstN)
    else $error("timeout not aborted by new cause");
  assert_pulse_a: assert property (status.assertPulse == $fell(rstOut.rstN))
    else $error("assert pulse does not match reset fall");
  release_pulse_a: assert property (status.releasePulse == $rose(rstOut.rstN))
    else $error("release pulse does not match reset rise");
endmodule : ssr_reset_gen_checker

//--- verif/ssr_mr_source.sv
`timescale 1ns/1ps
module ssr_mr_source (
  input wire logic clk,
  output logic manualResetN
);
  initial manualResetN = 1'h1;

  // Short pulses are allowed so that glitch rejection can be exercised.
  task automatic pulse(input int lowCyc);
    manualResetN = 1'h0;
    repeat (lowCyc) @(negedge clk);
    manualResetN = 1'h1;
  endtask : pulse
endmodule : ssr_mr_source

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ssr_pkg::*;
  localparam int unsigned NS = 8;
  localparam int unsigned NL = 16;
  localparam int unsigned NF = 4;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic supplyLow = 1'h0;
  logic manualResetN;
  logic timeoutSelectIn = 1'h0;
  ssr_rst_out_t rstOut;
  ssr_status_t status;
  int n_mismatch = 0;
  int compares = 0;

  always #25 clk = ~clk;

  ssr_mr_source ssr_mr_source_inst (.clk(clk), .manualResetN(manualResetN));
  ssr_reset_gen #(.TO_SHORT_CYC(NS), .TO_LONG_CYC(NL), .FILT_CYC(NF)) ssr_reset_gen_inst (
    .clk(clk), .sys_rst(sys_rst), .supplyLow(supplyLow), .manualResetN(manualResetN),
    .timeoutSelectIn(timeoutSelectIn), .rstOut(rstOut), .status(status));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Output must still be held after n edges and released on the next one.
  task automatic expect_release(input int n);
    repeat (n) @(negedge clk);
    chk("rstN held", 1'h0, rstOut.rstN);
    chk("rst held", 1'h1, rstOut.rst);
    chk("timing", 1'h1, status.timing);
    @(negedge clk);
    chk("rstN released", 1'h1, rstOut.rstN);
    chk("rst released", 1'h0, rstOut.rst);
    chk("release pulse", 1'h1, status.releasePulse);
    chk("timing done", 1'h0, status.timing);
  endtask : expect_release

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic supply_case(input logic sel, input int n, input int cnt);
    timeoutSelectIn = sel;
    supplyLow = 1'h1;
    @(negedge clk);
    chk("assert pulse", 1'h1, status.assertPulse);
    repeat (2) @(negedge clk);
    chk("rstN low", 1'h0, rstOut.rstN);
    chk("rst high", 1'h1, rstOut.rst);
    chk("supply cause", 1'h1, status.causeSupply);
    chk("reset count", cnt, status.resetCount);
    supplyLow = 1'h0;
    @(negedge clk);
    // A change of the select while timing must leave the period as it was.
    timeoutSelectIn = ~sel;
    expect_release(n - 1);
  endtask : supply_case

  task automatic manual_case;
    ssr_mr_source_inst.pulse(3);
    repeat (6) @(negedge clk);
    chk("glitch ignored", 1'h1, rstOut.rstN);
    chk("glitch not counted", 32'h2, status.resetCount);
    ssr_mr_source_inst.pulse(MR_MIN_PULSE_CYC);
    chk("manual low", 1'h0, rstOut.rstN);
    chk("manual cause", 1'h1, status.causeManual);
    chk("no supply cause", 1'h0, status.causeSupply);
    chk("manual count", 32'h3, status.resetCount);
    expect_release(NS + 1);
  endtask : manual_case

  task automatic abort_case;
    supplyLow = 1'h1;
    @(negedge clk);
    supplyLow = 1'h0;
    repeat (3) @(negedge clk);
    supplyLow = 1'h1;
    @(negedge clk);
    supplyLow = 1'h0;
    expect_release(NS);
    supplyLow = 1'h1;
    @(negedge clk);
    supplyLow = 1'h0;
    repeat (2) @(negedge clk);
    ssr_mr_source_inst.pulse(NF);
    expect_release(NS + 1);
    chk("both causes", 1'h1, status.causeManual & status.causeSupply);
    chk("abort count", 32'h5, status.resetCount);
  endtask : abort_case

  task automatic reset_case;
    sys_rst = 1'h1;
    @(negedge clk);
    chk("rstN in reset", 1'h0, rstOut.rstN);
    chk("rst in reset", 1'h1, rstOut.rst);
    chk("count in reset", 32'h0, status.resetCount);
    sys_rst = 1'h0;
    expect_release(NS);
  endtask : reset_case

  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    expect_release(NS);
    supply_case(1'h0, NS, 1);
    supply_case(1'h1, NL, 2);
    manual_case();
    abort_case();
    reset_case();
    stop_test();
  end
endmodule : testbench

bind ssr_reset_gen ssr_reset_gen_checker #(.TO_SHORT_CYC(TO_SHORT_CYC), .FILT_CYC(FILT_CYC))
  checker_inst (
  .clk(clk), .sys_rst(sys_rst), .supplyLow(supplyLow), .manualResetN(manualResetN),
  .timeoutSelectIn(timeoutSelectIn), .rstOut(rstOut), .status(status));
